// ===== shared/egp_pkg.sv
// Behaviour
// RULE_01: eight pins, each separately configured
// RULE_02: output mode drives data register bit
// RULE_03: output pins read back written value
// RULE_04: input pins read back sampled level
// RULE_05: direction 0 output, 1 input; reset 0
// RULE_06: output drive: hiz, pch, nch, cmos
// RULE_07: input: hiz, pull-down, pull-up, hiz
// RULE_08: control bits reset zero, hiz output
// RULE_09: control pair decoded by pin direction
// RULE_10: drive and pull set per bit
// RULE_11: pins 4/5 feed external timer clocks
// RULE_12: pins 0/1 two-wire bus or serial
// RULE_13: pin 2 rx/serial out, 3 tx
// RULE_14: pins 4-7 converter channel secondary
// RULE_15: tertiary pulses and serial on 3-7
// RULE_16: data/dir byte only; drive pair word
// RULE_17: function pair at 0xf224, word allowed
// RULE_18: function code gpio/second/third/prohibited
// RULE_19: prohibited output: hiz or driven low
// RULE_20: converter busy claims pins 4 to 7
// RULE_21: software uses hiz input for converter
// RULE_22: peripheral value replaces data bit
`default_nettype none
package egp_pkg;
    localparam int PIN_COUNT = 8;
    localparam logic [15:0] ADDR_DATA = 16'hF220;
    localparam logic [15:0] ADDR_DIR = 16'hF221;
    localparam logic [15:0] ADDR_DRV_LO = 16'hF222;
    localparam logic [15:0] ADDR_DRV_HI = 16'hF223;
    localparam logic [15:0] ADDR_FN_LO = 16'hF224;
    localparam logic [15:0] ADDR_FN_HI = 16'hF225;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [7:0] ALL_RELEASED = 8'hFF;
    localparam logic [1:0] FN_GPIO = 2'b00;
    localparam logic [1:0] FN_SECOND = 2'b01;
    localparam logic [1:0] FN_THIRD = 2'b10;
    localparam logic [1:0] FN_PROHIBITED = 2'b11;
    localparam logic [1:0] DRV_HIZ = 2'b00;
    localparam logic [1:0] DRV_PCH = 2'b01;
    localparam logic [1:0] DRV_NCH = 2'b10;
    localparam logic [1:0] DRV_CMOS = 2'b11;
    localparam logic [1:0] IN_PULL_DOWN = 2'b01;
    localparam logic [1:0] IN_PULL_UP = 2'b10;
    localparam int CONV_FIRST_PIN = 4;

    typedef struct packed {
        logic rd;
        logic wr;
        logic word;
        logic [15:0] addr;
        logic [15:0] wdata;
    } egp_sfr_req_t;

    typedef struct packed {
        logic bus_data_out;
        logic bus_clock_out;
        logic async_tx_line;
        logic clocked_serial_clock;
        logic clocked_serial_out;
        logic pulse_out_a;
        logic pulse_out_b;
        logic conv_ref_capacitor;
        logic conv_ref_resistor;
        logic conv_sensor_resistor;
    } egp_periph_out_t;

    typedef struct packed {
        logic bus_data_in;
        logic bus_clock_in;
        logic async_rx_line;
        logic clocked_serial_in;
        logic clocked_serial_clock;
        logic conv_osc_input;
        logic timer0_pulse0_ext_clock;
        logic timer1_pulse1_ext_clock;
    } egp_periph_in_t;
endpackage
`default_nettype wire

// ===== core/egp_port.sv
`default_nettype none
module egp_port (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,

    // cpu special function register access
    input wire egp_pkg::egp_sfr_req_t sfr_req,
    output logic [15:0] sfr_rdata,

    // package pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n,
    output logic [7:0] pull_up_en,
    output logic [7:0] pull_dn_en,

    // on-chip peripherals
    input wire egp_pkg::egp_periph_out_t periph_out,
    input wire logic conv_busy,
    output egp_pkg::egp_periph_in_t periph_in
);

    logic [7:0] port_data;
    logic [7:0] port_direction;
    logic [7:0] port_drive_ctrl_low;
    logic [7:0] port_drive_ctrl_high;
    logic [7:0] port_function_sel_low;
    logic [7:0] port_function_sel_high;

    // address decode
    wire byte_wr = sfr_req.wr && !sfr_req.word;
    wire word_wr = sfr_req.wr && sfr_req.word;
    wire hit_data = sfr_req.addr == egp_pkg::ADDR_DATA;
    wire hit_dir = sfr_req.addr == egp_pkg::ADDR_DIR;
    wire hit_drv_lo = sfr_req.addr == egp_pkg::ADDR_DRV_LO;
    wire hit_drv_hi = sfr_req.addr == egp_pkg::ADDR_DRV_HI;
    wire hit_fn_lo = sfr_req.addr == egp_pkg::ADDR_FN_LO;
    wire hit_fn_hi = sfr_req.addr == egp_pkg::ADDR_FN_HI;

    // word access only lands on the low address of a pair and writes both registers
    wire wr_data = byte_wr && hit_data; // [RULE_16]
    wire wr_dir = byte_wr && hit_dir; // [RULE_16]
    wire wr_drv_lo = sfr_req.wr && hit_drv_lo; // [RULE_16]
    wire wr_drv_hi = (byte_wr && hit_drv_hi) || (word_wr && hit_drv_lo); // [RULE_16]
    wire wr_fn_lo = sfr_req.wr && hit_fn_lo; // [RULE_17]
    wire wr_fn_hi = (byte_wr && hit_fn_hi) || (word_wr && hit_fn_lo); // [RULE_17]
    wire [7:0] wr_lo_byte = sfr_req.wdata[7:0];
    wire [7:0] wr_hi_byte = sfr_req.word ? sfr_req.wdata[15:8] : sfr_req.wdata[7:0];

    // register file
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            port_data <= egp_pkg::RESET_BYTE;
            port_direction <= egp_pkg::RESET_BYTE; // [RULE_05]
            port_drive_ctrl_low <= egp_pkg::RESET_BYTE; // [RULE_08]
            port_drive_ctrl_high <= egp_pkg::RESET_BYTE; // [RULE_08]
            port_function_sel_low <= egp_pkg::RESET_BYTE; // [RULE_17]
            port_function_sel_high <= egp_pkg::RESET_BYTE; // [RULE_17]
        end else begin
            if (wr_data) begin
                port_data <= wr_lo_byte;
            end
            if (wr_dir) begin
                port_direction <= wr_lo_byte;
            end
            if (wr_drv_lo) begin
                port_drive_ctrl_low <= wr_lo_byte;
            end
            if (wr_drv_hi) begin
                port_drive_ctrl_high <= wr_hi_byte;
            end
            if (wr_fn_lo) begin
                port_function_sel_low <= wr_lo_byte;
            end
            if (wr_fn_hi) begin
                port_function_sel_high <= wr_hi_byte;
            end
        end
    end

    // read path: output bits show the latch, input bits the pin
    wire [7:0] data_view = (port_data & ~port_direction) | (pin_in & port_direction); // [RULE_03] [RULE_04]
    wire rd_word = sfr_req.rd && sfr_req.word;
    wire rd_byte = sfr_req.rd && !sfr_req.word;
    logic [15:0] next_sfr_rdata;

    always_comb begin
        next_sfr_rdata = egp_pkg::RESET_WORD;
        if (rd_byte) begin
            case (sfr_req.addr)
                egp_pkg::ADDR_DATA: next_sfr_rdata = {8'h00, data_view};
                egp_pkg::ADDR_DIR: next_sfr_rdata = {8'h00, port_direction};
                egp_pkg::ADDR_DRV_LO: next_sfr_rdata = {8'h00, port_drive_ctrl_low};
                egp_pkg::ADDR_DRV_HI: next_sfr_rdata = {8'h00, port_drive_ctrl_high};
                egp_pkg::ADDR_FN_LO: next_sfr_rdata = {8'h00, port_function_sel_low};
                egp_pkg::ADDR_FN_HI: next_sfr_rdata = {8'h00, port_function_sel_high};
                default: next_sfr_rdata = egp_pkg::RESET_WORD;
            endcase
        end else if (rd_word) begin
            // only the two paired registers answer a word read
            case (sfr_req.addr)
                egp_pkg::ADDR_DRV_LO: next_sfr_rdata = {port_drive_ctrl_high, port_drive_ctrl_low}; // [RULE_16]
                egp_pkg::ADDR_FN_LO: next_sfr_rdata = {port_function_sel_high, port_function_sel_low}; // [RULE_17]
                default: next_sfr_rdata = egp_pkg::RESET_WORD;
            endcase
        end
    end

    // peripheral values offered to each pin
    wire [7:0] second_val = {
        periph_out.conv_sensor_resistor,
        periph_out.conv_ref_resistor,
        periph_out.conv_ref_capacitor,
        1'b0,
        periph_out.async_tx_line,
        1'b1,
        periph_out.bus_clock_out,
        periph_out.bus_data_out
    }; // [RULE_12] [RULE_13] [RULE_14]
    wire [7:0] third_val = {
        periph_out.pulse_out_b,
        periph_out.clocked_serial_out,
        periph_out.clocked_serial_clock,
        1'b1,
        periph_out.pulse_out_a,
        periph_out.clocked_serial_out,
        periph_out.clocked_serial_clock,
        1'b1
    }; // [RULE_12] [RULE_13] [RULE_15]

    logic [7:0] fn_second;
    logic [7:0] fn_third;
    logic [7:0] next_pin_out;
    logic [7:0] next_pin_oe_n;
    logic [7:0] next_pull_up_en;
    logic [7:0] next_pull_dn_en;

    genvar i;
    generate
        for (i = 0; i < egp_pkg::PIN_COUNT; i++) begin : g_pin // [RULE_01] [RULE_10]
            wire conv_claim = (i >= egp_pkg::CONV_FIRST_PIN) && conv_busy;
            wire [1:0] fn_sel = conv_claim ? egp_pkg::FN_SECOND
                : {port_function_sel_high[i], port_function_sel_low[i]}; // [RULE_18] [RULE_20]
            wire [1:0] ctl = {port_drive_ctrl_high[i], port_drive_ctrl_low[i]};
            wire is_out = !port_direction[i]; // [RULE_05] [RULE_09]
            wire prohibited = fn_sel == egp_pkg::FN_PROHIBITED;
            wire out_val = (fn_sel == egp_pkg::FN_SECOND) ? second_val[i]
                : (fn_sel == egp_pkg::FN_THIRD) ? third_val[i]
                : port_data[i]; // [RULE_02] [RULE_22]
            wire val = prohibited ? 1'b0 : out_val; // [RULE_19]
            logic drive;

            always_comb begin
                drive = 1'b0;
                if (is_out) begin
                    case (ctl) // [RULE_06]
                        egp_pkg::DRV_HIZ: drive = 1'b0;
                        egp_pkg::DRV_PCH: drive = !prohibited && val; // [RULE_19]
                        egp_pkg::DRV_NCH: drive = !val;
                        egp_pkg::DRV_CMOS: drive = 1'b1;
                        default: drive = 1'b0;
                    endcase
                end
            end

            assign fn_second[i] = fn_sel == egp_pkg::FN_SECOND;
            assign fn_third[i] = fn_sel == egp_pkg::FN_THIRD;
            assign next_pin_out[i] = val;
            assign next_pin_oe_n[i] = !drive;
            assign next_pull_up_en[i] = !is_out && ctl == egp_pkg::IN_PULL_UP; // [RULE_07] [RULE_09]
            assign next_pull_dn_en[i] = !is_out && ctl == egp_pkg::IN_PULL_DOWN; // [RULE_07] [RULE_09]
        end
    endgenerate

    // inputs handed to peripherals idle high when the pin is not theirs, except the converter oscillator input, which idles low
    egp_pkg::egp_periph_in_t next_periph_in;

    always_comb begin
        next_periph_in = '1;
        next_periph_in.bus_data_in = fn_second[0] ? pin_in[0] : 1'b1; // [RULE_12]
        next_periph_in.bus_clock_in = fn_second[1] ? pin_in[1] : 1'b1; // [RULE_12]
        next_periph_in.async_rx_line = fn_second[2] ? pin_in[2] : 1'b1; // [RULE_13]
        // pin 4 wins when both serial input pins are selected
        next_periph_in.clocked_serial_in = fn_third[4] ? pin_in[4]
            : fn_third[0] ? pin_in[0] : 1'b1; // [RULE_12] [RULE_15]
        next_periph_in.clocked_serial_clock = fn_third[5] ? pin_in[5]
            : fn_third[1] ? pin_in[1] : 1'b1; // [RULE_12] [RULE_15]
        next_periph_in.conv_osc_input = fn_second[4] ? pin_in[4] : 1'b0; // [RULE_14]
        // clock taps stay live in every mode, as the timer may count a pin it drives
        next_periph_in.timer0_pulse0_ext_clock = pin_in[4]; // [RULE_11]
        next_periph_in.timer1_pulse1_ext_clock = pin_in[5]; // [RULE_11]
    end

    // all outputs registered; reset leaves every pin released
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sfr_rdata <= egp_pkg::RESET_WORD;
            pin_out <= egp_pkg::RESET_BYTE;
            pin_oe_n <= egp_pkg::ALL_RELEASED; // [RULE_08]
            pull_up_en <= egp_pkg::RESET_BYTE;
            pull_dn_en <= egp_pkg::RESET_BYTE;
            periph_in <= '1;
        end else begin
            sfr_rdata <= next_sfr_rdata;
            pin_out <= next_pin_out;
            pin_oe_n <= next_pin_oe_n;
            pull_up_en <= next_pull_up_en;
            pull_dn_en <= next_pull_dn_en;
            periph_in <= next_periph_in;
        end
    end

endmodule
`default_nettype wire

// ===== dv/egp_checker.sv
`default_nettype none
module egp_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // register bus
    input wire egp_pkg::egp_sfr_req_t sfr_req,
    input wire logic [15:0] sfr_rdata,
    // pins
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pull_up_en,
    input wire logic [7:0] pull_dn_en,
    // peripherals
    input wire egp_pkg::egp_periph_out_t periph_out,
    input wire logic conv_busy,
    input wire egp_pkg::egp_periph_in_t periph_in
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    wire hit = sfr_req.addr >= 16'hf220 && sfr_req.addr <= 16'hf225;
    rst_state_a: assert property ($past(sys_rst) |-> pin_oe_n == 8'hff && pin_out == 8'h00)
        else $error("pins not released after reset");
    rdata_idle_a: assert property (!sfr_req.rd |=> sfr_rdata == 16'h0000)
        else $error("read data not idle");
    pull_excl_a: assert property ((pull_up_en & pull_dn_en) == 8'h00)
        else $error("both pulls on");
    drive_nopull_a: assert property ((~pin_oe_n & (pull_up_en | pull_dn_en)) == 8'h00)
        else $error("pull on a driven pin");
    tmr0_clock_a: assert property (1'b1 |=> periph_in.timer0_pulse0_ext_clock == $past(pin_in[4]))
        else $error("timer 0 clock not from pin 4");
    tmr1_clock_a: assert property (!$past(sys_rst) |-> periph_in.timer1_pulse1_ext_clock == $past(pin_in[5]))
        else $error("timer 1 clock not from pin 5");
    byte_upper_a: assert property (sfr_req.rd && !sfr_req.word |=> sfr_rdata[15:8] == 8'h00)
        else $error("byte read upper half not zero");
    unmapped_zero_a: assert property (sfr_req.rd && !hit |=> sfr_rdata == 16'h0000)
        else $error("unmapped read not zero");
endmodule
bind egp_port egp_checker i_egp_checker (.mclk(mclk), .sys_rst(sys_rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en),
    .periph_out(periph_out), .conv_busy(conv_busy), .periph_in(periph_in));
`default_nettype wire

// ===== dv/egp_pins_model.sv
`default_nettype none
module egp_pins_model (
    // clock
    input wire logic mclk,
    // design side
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pull_up_en,
    input wire logic [7:0] pull_dn_en,
    // outside drivers
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] drift = 8'h00;
    // a floating pin must never look like a steady level
    always @(posedge mclk) drift <= ~drift;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else if (pull_up_en[i]) pin_in[i] = 1'b1;
            else if (pull_dn_en[i]) pin_in[i] = 1'b0;
            else pin_in[i] = drift[i];
        end
    end
endmodule
`default_nettype wire

// ===== dv/test_egp_port.sv
`default_nettype none
module test_egp_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    egp_pkg::egp_sfr_req_t sfr_req = '0;
    egp_pkg::egp_periph_out_t periph_out = '0;
    logic conv_busy = 1'b0;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic [15:0] sfr_rdata;
    logic [7:0] pin_in, pin_out, pin_oe_n, pull_up_en, pull_dn_en;
    egp_pkg::egp_periph_in_t periph_in;
    int num_errors = 0;
    int n_compared = 0;
    always #2 mclk = ~mclk;
    egp_port i_egp_port (.mclk(mclk), .sys_rst(sys_rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en),
        .periph_out(periph_out), .conv_busy(conv_busy), .periph_in(periph_in));
    egp_pins_model i_egp_pins_model (.mclk(mclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en),
        .pull_dn_en(pull_dn_en), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [15:0] pv();
        return {pin_oe_n, pin_out & ~pin_oe_n};
    endfunction
    task automatic req(input logic w, input logic wd, input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        #1;
        sfr_req = '{rd: !w, wr: w, word: wd, addr: a, wdata: d};
        @(posedge mclk);
        #1;
        sfr_req.rd = 1'b0;
        sfr_req.wr = 1'b0;
    endtask
    task automatic rd_chk(input logic wd, input logic [15:0] a, input logic [15:0] exp);
        req(1'b0, wd, a, 16'h0000);
        chk("rdata", exp, sfr_rdata);
    endtask
    task automatic sett();
        @(posedge mclk);
        #1;
    endtask
    task automatic t_reset();
        chk("pins", 16'hff00, {pin_oe_n, pin_out});
        for (int i = 0; i < 6; i++) rd_chk(1'b0, 16'hf220 + 16'(i), 16'h0000);
    endtask
    task automatic t_drive();
        logic [7:0] eo[4] = '{8'hff, 8'h5a, 8'ha5, 8'h00};
        req(1'b1, 1'b0, 16'hf220, 16'h00a5);
        for (int m = 0; m < 4; m++) begin
            req(1'b1, 1'b1, 16'hf222, {{8{m[1]}}, {8{m[0]}}});
            sett();
            chk("pins", {eo[m], 8'ha5 & ~eo[m]}, pv());
        end
        rd_chk(1'b0, 16'hf220, 16'h00a5);
    endtask
    task automatic t_input();
        req(1'b1, 1'b0, 16'hf221, 16'h00ff);
        for (int m = 0; m < 4; m++) begin
            req(1'b1, 1'b1, 16'hf222, {{8{m[1]}}, {8{m[0]}}});
            sett();
            chk("pins", 16'hff00, pv());
            chk("pulls", {(m == 2) ? 8'hff : 8'h00, (m == 1) ? 8'hff : 8'h00}, {pull_up_en, pull_dn_en});
            if (m == 1 || m == 2) rd_chk(1'b0, 16'hf220, (m == 2) ? 16'h00ff : 16'h0000);
        end
        ext_en = 8'hff;
        ext_val = 8'h3c;
        rd_chk(1'b0, 16'hf220, 16'h003c);
        ext_en = 8'h00;
    endtask
    task automatic t_mixed();
        req(1'b1, 1'b0, 16'hf220, 16'h00f0);
        req(1'b1, 1'b0, 16'hf221, 16'h000f);
        req(1'b1, 1'b1, 16'hf222, 16'haa55);
        sett();
        chk("pins", 16'haf50, pv());
        chk("pulls", 16'h0a05, {pull_up_en, pull_dn_en});
        rd_chk(1'b0, 16'hf220, 16'h00fa);
    endtask
    task automatic t_func();
        req(1'b1, 1'b0, 16'hf220, 16'h00ff);
        req(1'b1, 1'b0, 16'hf221, 16'h0000);
        req(1'b1, 1'b1, 16'hf222, 16'hffff);
        req(1'b1, 1'b1, 16'hf224, 16'h0903);
        sett();
        chk("pins", 16'h00f4, pv());
        periph_out.pulse_out_a = 1'b1;
        periph_out.bus_clock_out = 1'b1;
        sett();
        chk("pins", 16'h00fe, pv());
        conv_busy = 1'b1;
        sett();
        chk("pins", 16'h000e, pv());
        periph_out.conv_sensor_resistor = 1'b1;
        sett();
        chk("pins", 16'h008e, pv());
        conv_busy = 1'b0;
        req(1'b1, 1'b1, 16'hf222, 16'h00ff);
        sett();
        chk("pins", 16'h01fe, pv());
        rd_chk(1'b1, 16'hf224, 16'h0903);
        // refused accesses leave state alone and read as zero
        req(1'b1, 1'b1, 16'hf220, 16'h0000);
        rd_chk(1'b0, 16'hf220, 16'h00ff);
        rd_chk(1'b1, 16'hf220, 16'h0000);
        req(1'b1, 1'b0, 16'hf226, 16'h0055);
        rd_chk(1'b0, 16'hf226, 16'h0000);
    endtask
    // converter pins left as plain high-impedance inputs, so no pull fights the sensor
    task automatic t_periph();
        req(1'b1, 1'b0, 16'hf221, 16'h00f0);
        req(1'b1, 1'b1, 16'hf222, 16'h0000);
        req(1'b1, 1'b1, 16'hf224, 16'h0007);
        ext_en = 8'h3f;
        ext_val = 8'h15;
        conv_busy = 1'b1;
        sett();
        sett();
        chk("pulls", 16'h0000, {pull_up_en, pull_dn_en});
        chk("periph_in", 16'h00be, {8'h00, periph_in});
        conv_busy = 1'b0;
        ext_val = 8'h2a;
        sett();
        sett();
        chk("periph_in", 16'h0059, {8'h00, periph_in});
        ext_en = 8'h00;
    endtask
    task automatic complete_run();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #20000;
        num_errors++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        t_reset();
        t_drive();
        t_input();
        t_mixed();
        t_func();
        t_periph();
        complete_run();
    end
endmodule
`default_nettype wire
